// ### ocg_clock_ctrl.sv
// oscillator gating, base clock selection and pll control register interlocks
`timescale 1ns/10ps

//
// Contract
// - watchdog clock always from rc oscillator
// - rc clock runs after reset, run, wait
// - rc disable bit resets 0; stops rc in stop only
// - sysint enable gates rc and crystal oscillators
// - rc clock feeds sysint and watchdog
// - pll reference is buffered crystal clock
// - wait leaves all oscillator clocks running
// - stop halts crystal unless keep bit set
// - kept crystal clock keeps clocking rtc
// - break keeps all clocks running
// - base clock: crystal, crystal/2, pll/2
// - bus clock is half base clock
// - auto off: irq enable held 0
// - auto off: flag and lock read 0
// - auto on: acquisition bit read-only
// - pll off or range zero: bcs 0
// - pll on: programming register read-only
// - bcs set: pll on forced, locked
// - interrupt on lock entry and exit
// - auto and irq enable: irq on toggle
// - bcs set selects pll/2 source
module ocg_clock_ctrl (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             arst_n_in,
  // register port
  input  wire ocg_pkg::ocg_req_s reg_req_in,
  output logic [7:0]            reg_rdata_out,
  // system integration module
  input  wire logic             osc_enable_from_sysint_in,
  input  wire logic             stop_mode_in,
  input  wire logic             wait_mode_in,
  input  wire logic             break_mode_in,
  // analog oscillator and pll pins
  input  wire logic             rc_osc_pin_in,
  input  wire logic             xtal_amp_in,
  input  wire logic             pll_divided_clk_in,
  input  wire logic             pll_lock_pin_in,
  input  wire logic             pll_acq_pin_in,
  // analog controls
  output logic                  rc_osc_en_out,
  output logic                  xtal_osc_en_out,
  output logic                  pll_power_on_out,
  output logic                  acquisition_mode_bit_out,
  output logic [7:0]            vco_range_select_out,
  // clocks to consumers
  output logic                  watchdog_clk_out,
  output logic                  sysint_clk_out,
  output logic                  xtal_clk_out,
  output logic                  pll_ref_clk_out,
  output logic                  rtc_clk_out,
  output logic                  base_clk_out,
  output logic                  bus_clk_out,
  // interrupt request
  output logic                  pll_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [ocg_pkg::SYNC_W-1:0] sync1_q;
  logic [ocg_pkg::SYNC_W-1:0] sync2_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {pll_acq_pin_in, pll_lock_pin_in, pll_divided_clk_in,
                  xtal_amp_in, rc_osc_pin_in};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic       irq_en_q,    irq_en_d;
  logic       irq_flag_q,  irq_flag_d;
  logic       pll_on_q,    pll_on_d;
  logic       bcs_q,       bcs_d;
  logic       auto_q,      auto_d;
  logic       acq_q,       acq_d;
  logic [7:0] vrs_q,       vrs_d;
  logic       keep_q,      keep_d;
  logic       rcdis_q,     rcdis_d;
  logic       nodiv_q,     nodiv_d;
  logic       lock_prev_q, lock_prev_d;
  logic [7:0] rdata_q,     rdata_d;
  logic       stop_lat_q,  stop_lat_d;
  logic       keep_lat_q,  keep_lat_d;
  logic       rcdis_lat_q, rcdis_lat_d;
  logic       rc_on_q,     rc_on_d;
  logic       xtal_on_q,   xtal_on_d;
  ocg_pkg::ocg_src_e cur_src_q, cur_src_d;

  logic lock_s;
  logic acq_s;
  logic wr_ctrl;
  logic wr_bw;
  logic rd_ctrl;
  logic lock_toggle;

  function automatic logic hit(input logic stb, input logic [2:0] a, input logic [2:0] ofs);
    hit = stb && (a == ofs);
  endfunction : hit

  assign lock_s      = sync2_q[ocg_pkg::LANE_LOCK];
  assign acq_s       = sync2_q[ocg_pkg::LANE_ACQ];
  assign wr_ctrl     = hit(reg_req_in.wr, reg_req_in.addr, ocg_pkg::OFS_PLL_CTRL);
  assign wr_bw       = hit(reg_req_in.wr, reg_req_in.addr, ocg_pkg::OFS_BANDWIDTH);
  assign rd_ctrl     = hit(reg_req_in.rd, reg_req_in.addr, ocg_pkg::OFS_PLL_CTRL);
  assign lock_toggle = lock_s ^ lock_prev_q;

  always_comb begin
    irq_en_d    = irq_en_q;
    irq_flag_d  = irq_flag_q;
    pll_on_d    = pll_on_q;
    bcs_d       = bcs_q;
    auto_d      = auto_q;
    acq_d       = acq_q;
    vrs_d       = vrs_q;
    keep_d      = keep_q;
    rcdis_d     = rcdis_q;
    nodiv_d     = nodiv_q;
    lock_prev_d = lock_s;
    if (wr_bw) begin
      auto_d = reg_req_in.wdata[ocg_pkg::BIT_AUTO];
      if (!auto_q) begin
        acq_d = reg_req_in.wdata[ocg_pkg::BIT_ACQ];
      end
    end
    if (auto_d) begin
      acq_d = acq_s;
    end
    if (wr_ctrl) begin
      irq_en_d = reg_req_in.wdata[ocg_pkg::BIT_IRQ_EN];
      bcs_d    = reg_req_in.wdata[ocg_pkg::BIT_BCS];
      pll_on_d = reg_req_in.wdata[ocg_pkg::BIT_PLL_ON] | bcs_q;
    end
    // programming register only moves while the pll is powered down
    if (hit(reg_req_in.wr, reg_req_in.addr, ocg_pkg::OFS_PLL_PROG) && !pll_on_q) begin
      vrs_d = reg_req_in.wdata;
    end
    if (hit(reg_req_in.wr, reg_req_in.addr, ocg_pkg::OFS_CONFIG_TWO)) begin
      keep_d  = reg_req_in.wdata[ocg_pkg::BIT_XTAL_KEEP];
      rcdis_d = reg_req_in.wdata[ocg_pkg::BIT_RC_DISABLE];
      nodiv_d = reg_req_in.wdata[ocg_pkg::BIT_XTAL_NODIV];
    end
    if (!pll_on_d || vrs_d == 8'h00) begin
      bcs_d = 1'b0;
    end
    if (!auto_d) begin
      irq_en_d = 1'b0;
    end
    // read of control clears the flag; a toggle in the same cycle wins
    if (rd_ctrl) begin
      irq_flag_d = 1'b0;
    end
    if (auto_q && lock_toggle) begin
      irq_flag_d = 1'b1;
    end
    if (!auto_d) begin
      irq_flag_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        ocg_pkg::OFS_PLL_CTRL: begin
          rdata_d[ocg_pkg::BIT_IRQ_EN]   = irq_en_q;
          rdata_d[ocg_pkg::BIT_IRQ_FLAG] = irq_flag_q & auto_q;
          rdata_d[ocg_pkg::BIT_PLL_ON]   = pll_on_q;
          rdata_d[ocg_pkg::BIT_BCS]      = bcs_q;
        end
        ocg_pkg::OFS_BANDWIDTH: begin
          rdata_d[ocg_pkg::BIT_AUTO] = auto_q;
          rdata_d[ocg_pkg::BIT_LOCK] = lock_s & auto_q;
          rdata_d[ocg_pkg::BIT_ACQ]  = acq_q;
        end
        ocg_pkg::OFS_PLL_PROG: begin
          rdata_d = vrs_q;
        end
        ocg_pkg::OFS_CONFIG_TWO: begin
          rdata_d[ocg_pkg::BIT_XTAL_NODIV] = nodiv_q;
          rdata_d[ocg_pkg::BIT_XTAL_KEEP]  = keep_q;
          rdata_d[ocg_pkg::BIT_RC_DISABLE] = rcdis_q;
        end
        ocg_pkg::OFS_CLK_STATUS: begin
          rdata_d[ocg_pkg::BIT_ST_RC]    = rc_on_q;
          rdata_d[ocg_pkg::BIT_ST_XTAL]  = xtal_on_q;
          rdata_d[ocg_pkg::BIT_ST_STOPL] = stop_lat_q;
          rdata_d[ocg_pkg::BIT_ST_SRC+1:ocg_pkg::BIT_ST_SRC] = cur_src_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop entry latch and oscillator enables

  always_comb begin
    stop_lat_d  = stop_mode_in;
    keep_lat_d  = keep_lat_q;
    rcdis_lat_d = rcdis_lat_q;
    // sample once on entry; later writes wait until stop is left
    if (stop_mode_in && !stop_lat_q) begin
      keep_lat_d  = keep_q;
      rcdis_lat_d = rcdis_q;
    end
    // wait is deliberately not looked at: it changes nothing here
    if (break_mode_in) begin
      rc_on_d   = 1'b1;
      xtal_on_d = 1'b1;
    end else if (stop_lat_d) begin
      rc_on_d   = !rcdis_lat_d;
      xtal_on_d = keep_lat_d;
    end else begin
      rc_on_d   = osc_enable_from_sysint_in;
      xtal_on_d = osc_enable_from_sysint_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gated clocks and dividers
  logic rc_clk_q,     rc_clk_d;
  logic xtal_clk_q,   xtal_clk_d;
  logic xtal_div2_q,  xtal_div2_d;
  logic pll_src_q,    pll_src_d;
  logic pll_div2_q,   pll_div2_d;
  logic base_q,       base_d;
  logic bus_q,        bus_d;
  logic irq_q,        irq_d;
  ocg_pkg::ocg_src_e  want_src;
  logic              next_lvl;

  function automatic logic src_level(input ocg_pkg::ocg_src_e s, input logic x,
                                     input logic xd, input logic pd);
    case (s)
      ocg_pkg::SRC_XTAL:      src_level = x;
      ocg_pkg::SRC_XTAL_DIV2: src_level = xd;
      ocg_pkg::SRC_PLL_DIV2:  src_level = pd;
      default:                src_level = 1'b0;
    endcase
  endfunction : src_level

  always_comb begin
    rc_clk_d    = sync2_q[ocg_pkg::LANE_RC] & rc_on_q;
    xtal_clk_d  = sync2_q[ocg_pkg::LANE_XTAL] & xtal_on_q;
    pll_src_d   = sync2_q[ocg_pkg::LANE_PLL] & pll_on_q;
    xtal_div2_d = xtal_div2_q ^ (xtal_clk_d & !xtal_clk_q);
    pll_div2_d  = pll_div2_q ^ (pll_src_d & !pll_src_q);
    if (bcs_q) begin
      want_src = ocg_pkg::SRC_PLL_DIV2;
    end else if (nodiv_q) begin
      want_src = ocg_pkg::SRC_XTAL;
    end else begin
      want_src = ocg_pkg::SRC_XTAL_DIV2;
    end
    cur_src_d = cur_src_q;
    // switch only with output and new source both low: low phase stretches, never cut
    next_lvl = src_level(want_src, xtal_clk_d, xtal_div2_d, pll_div2_d);
    if (want_src != cur_src_q && !base_q && !next_lvl) begin
      cur_src_d = want_src;
    end
    if (cur_src_d != cur_src_q) begin
      base_d = next_lvl;
    end else if (want_src != cur_src_q && !base_q) begin
      base_d = 1'b0;
    end else begin
      base_d = src_level(cur_src_q, xtal_clk_d, xtal_div2_d, pll_div2_d);
    end
    bus_d = bus_q ^ (base_d & !base_q);
    irq_d = irq_flag_d & irq_en_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_en_q    <= ocg_pkg::RST_BIT;
      irq_flag_q  <= ocg_pkg::RST_BIT;
      pll_on_q    <= ocg_pkg::RST_BIT;
      bcs_q       <= ocg_pkg::RST_BIT;
      auto_q      <= ocg_pkg::RST_BIT;
      acq_q       <= ocg_pkg::RST_BIT;
      vrs_q       <= ocg_pkg::RST_VCO_RANGE;
      keep_q      <= ocg_pkg::RST_BIT;
      rcdis_q     <= ocg_pkg::RST_BIT;
      nodiv_q     <= ocg_pkg::RST_BIT;
      lock_prev_q <= ocg_pkg::RST_BIT;
      rdata_q     <= 8'h00;
      stop_lat_q  <= ocg_pkg::RST_BIT;
      keep_lat_q  <= ocg_pkg::RST_BIT;
      rcdis_lat_q <= ocg_pkg::RST_BIT;
      rc_on_q     <= 1'b1;
      xtal_on_q   <= 1'b1;
      rc_clk_q    <= 1'b0;
      xtal_clk_q  <= 1'b0;
      xtal_div2_q <= 1'b0;
      pll_src_q   <= 1'b0;
      pll_div2_q  <= 1'b0;
      base_q      <= 1'b0;
      bus_q       <= 1'b0;
      irq_q       <= 1'b0;
      cur_src_q   <= ocg_pkg::SRC_XTAL_DIV2;
    end else begin
      irq_en_q    <= irq_en_d;
      irq_flag_q  <= irq_flag_d;
      pll_on_q    <= pll_on_d;
      bcs_q       <= bcs_d;
      auto_q      <= auto_d;
      acq_q       <= acq_d;
      vrs_q       <= vrs_d;
      keep_q      <= keep_d;
      rcdis_q     <= rcdis_d;
      nodiv_q     <= nodiv_d;
      lock_prev_q <= lock_prev_d;
      rdata_q     <= rdata_d;
      stop_lat_q  <= stop_lat_d;
      keep_lat_q  <= keep_lat_d;
      rcdis_lat_q <= rcdis_lat_d;
      rc_on_q     <= rc_on_d;
      xtal_on_q   <= xtal_on_d;
      rc_clk_q    <= rc_clk_d;
      xtal_clk_q  <= xtal_clk_d;
      xtal_div2_q <= xtal_div2_d;
      pll_src_q   <= pll_src_d;
      pll_div2_q  <= pll_div2_d;
      base_q      <= base_d;
      bus_q       <= bus_d;
      irq_q       <= irq_d;
      cur_src_q   <= cur_src_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop
  assign reg_rdata_out            = rdata_q;
  assign rc_osc_en_out            = rc_on_q;
  assign xtal_osc_en_out          = xtal_on_q;
  assign pll_power_on_out         = pll_on_q;
  assign acquisition_mode_bit_out = acq_q;
  assign vco_range_select_out     = vrs_q;
  assign watchdog_clk_out         = rc_clk_q;
  assign sysint_clk_out           = rc_clk_q;
  assign xtal_clk_out             = xtal_clk_q;
  assign pll_ref_clk_out          = xtal_clk_q;
  assign rtc_clk_out              = xtal_clk_q;
  assign base_clk_out             = base_q;
  assign bus_clk_out              = bus_q;
  assign pll_irq_out              = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_bcs_write;
    wr_ctrl && reg_req_in.wdata[ocg_pkg::BIT_BCS] && pll_on_q && vrs_q != 8'h00;
  endsequence
  sequence s_pll_source_taken;
    ##[1:40] cur_src_q == ocg_pkg::SRC_PLL_DIV2;
  endsequence

  a_irq_en_held: assert property (!auto_q |-> !irq_en_q)
    else $error("irq enable set while auto is off");
  a_flag_masked: assert property (!auto_q |-> !irq_flag_q && !pll_irq_out)
    else $error("irq flag or request while auto is off");
  a_lock_edge_irq: assert property (auto_q && auto_d && lock_toggle |=> irq_flag_q)
    else $error("lock change did not set the irq flag");
  a_irq_follows: assert property (irq_flag_q && irq_en_q && !rd_ctrl && !wr_ctrl && auto_d
      |=> pll_irq_out)
    else $error("enabled flag did not raise the interrupt");
  a_acq_ro: assert property (auto_q && $past(auto_q) |-> acq_q == $past(acq_s))
    else $error("acquisition bit not tracking status in auto mode");
  a_bcs_forced: assert property (!pll_on_q || vrs_q == 8'h00 |-> !bcs_q)
    else $error("base select set without pll or range");
  a_prog_locked: assert property (pll_on_q |=> vrs_q == $past(vrs_q))
    else $error("programming register changed with pll on");
  a_pll_on_held: assert property (bcs_q |=> pll_on_q)
    else $error("pll powered down while selected");
  a_pll_select: assert property (s_bcs_write |-> s_pll_source_taken)
    else $error("pll source not taken after select");
  a_no_short_high: assert property ($rose(base_q) && cur_src_q == ocg_pkg::SRC_XTAL_DIV2
      |=> base_q [*2])
    else $error("base clock high phase cut short");
  a_stop_keep: assert property (stop_lat_q && !break_mode_in && !$past(break_mode_in)
      && !keep_lat_q |=> !xtal_clk_q)
    else $error("crystal clock running in stop without keep");
  a_break_run: assert property (break_mode_in |=> rc_on_q && xtal_on_q)
    else $error("oscillator stopped in break");
  a_wait_run: assert property (wait_mode_in && !stop_mode_in && !break_mode_in
      && osc_enable_from_sysint_in |=> rc_on_q && xtal_on_q)
    else $error("oscillator stopped in wait");
  a_stop_latch: assert property (stop_lat_q && $past(stop_lat_q) |-> $stable(keep_lat_q))
    else $error("stop bits changed during stop");

endmodule : ocg_clock_ctrl

// ### ocg_pkg.sv
// package: register map, field layout, enumerations and carriers of the clock gating block
package ocg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [2:0] OFS_PLL_CTRL   = 3'h0;
  localparam logic [2:0] OFS_BANDWIDTH  = 3'h1;
  localparam logic [2:0] OFS_PLL_PROG   = 3'h2;
  localparam logic [2:0] OFS_CONFIG_TWO = 3'h3;
  localparam logic [2:0] OFS_CLK_STATUS = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // pll control fields
  localparam int unsigned BIT_IRQ_EN   = 7;
  localparam int unsigned BIT_IRQ_FLAG = 6;
  localparam int unsigned BIT_PLL_ON   = 5;
  localparam int unsigned BIT_BCS      = 4;
  // bandwidth control fields
  localparam int unsigned BIT_AUTO     = 7;
  localparam int unsigned BIT_LOCK     = 6;
  localparam int unsigned BIT_ACQ      = 5;
  // config two fields
  localparam int unsigned BIT_XTAL_NODIV = 2;
  localparam int unsigned BIT_XTAL_KEEP  = 1;
  localparam int unsigned BIT_RC_DISABLE = 0;
  // clock status fields
  localparam int unsigned BIT_ST_RC    = 0;
  localparam int unsigned BIT_ST_XTAL  = 1;
  localparam int unsigned BIT_ST_STOPL = 2;
  localparam int unsigned BIT_ST_SRC   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_VCO_RANGE = 8'h00;
  localparam logic       RST_BIT       = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser lanes
  localparam int unsigned SYNC_W    = 5;
  localparam int unsigned LANE_RC   = 0;
  localparam int unsigned LANE_XTAL = 1;
  localparam int unsigned LANE_PLL  = 2;
  localparam int unsigned LANE_LOCK = 3;
  localparam int unsigned LANE_ACQ  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // base clock sources
  typedef enum logic [1:0] {
    SRC_XTAL      = 2'b00,
    SRC_XTAL_DIV2 = 2'b01,
    SRC_PLL_DIV2  = 2'b10
  } ocg_src_e;

  // register bus request carrier
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ocg_req_s;

endpackage : ocg_pkg

// ### ocg_osc_model.sv
// behavioural oscillators, pll and lock detector on the far side of the clock block
`timescale 1ns/10ps
module ocg_osc_model #(
  parameter time RC_HALF   = 170,
  parameter time XTAL_HALF = 110,
  parameter time PLL_HALF  = 130
) (
  // enables from the block
  input  wire logic rc_en_in,
  input  wire logic xtal_en_in,
  input  wire logic pll_on_in,
  // lock and acquisition commands from the bench
  input  wire logic lock_cmd_in,
  input  wire logic acq_cmd_in,
  // raw pins
  output logic      rc_pin_out,
  output logic      xtal_pin_out,
  output logic      pll_pin_out,
  output logic      lock_pin_out,
  output logic      acq_pin_out
);
  initial begin
    rc_pin_out = 1'b0;
    xtal_pin_out = 1'b0;
    pll_pin_out = 1'b0;
  end
  // a disabled core freezes where it stopped, no free-running edges
  always #RC_HALF if (rc_en_in === 1'b1) rc_pin_out = ~rc_pin_out;
  always #XTAL_HALF if (xtal_en_in === 1'b1) xtal_pin_out = ~xtal_pin_out;
  always #PLL_HALF if (pll_on_in === 1'b1) pll_pin_out = ~pll_pin_out;
  // lock detector is dead while the loop is powered down
  always_comb lock_pin_out = lock_cmd_in & pll_on_in;
  always_comb acq_pin_out = acq_cmd_in & pll_on_in;
endmodule : ocg_osc_model

// ### testbench.sv
// self-checking bench for the oscillator gating and base clock select block
`timescale 1ns/10ps
module testbench;
  logic              clk_sys_in, arst_n_in;
  ocg_pkg::ocg_req_s req;
  logic [7:0]        rdata, vrs, d;
  logic              osc_en, stop_m, wait_m, brk_m, lock_cmd, acq_cmd;
  logic              rc_pin, xt_pin, pll_pin, lock_pin, acq_pin;
  logic              rc_en, xt_en, pll_on, acq_o, wd, sy, xt, pref, rtc, base, bus, irq;
  logic [4:0]        prv;
  int                n_mismatch, compares, cyc, n_wd, n_xt, n_base, n_bus, n_pll;

  ocg_clock_ctrl uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .osc_enable_from_sysint_in(osc_en), .stop_mode_in(stop_m),
    .wait_mode_in(wait_m), .break_mode_in(brk_m), .rc_osc_pin_in(rc_pin), .xtal_amp_in(xt_pin),
    .pll_divided_clk_in(pll_pin), .pll_lock_pin_in(lock_pin), .pll_acq_pin_in(acq_pin),
    .rc_osc_en_out(rc_en), .xtal_osc_en_out(xt_en), .pll_power_on_out(pll_on),
    .acquisition_mode_bit_out(acq_o), .vco_range_select_out(vrs), .watchdog_clk_out(wd),
    .sysint_clk_out(sy), .xtal_clk_out(xt), .pll_ref_clk_out(pref), .rtc_clk_out(rtc),
    .base_clk_out(base), .bus_clk_out(bus), .pll_irq_out(irq));
  ocg_osc_model osc (.rc_en_in(rc_en), .xtal_en_in(xt_en), .pll_on_in(pll_on),
    .lock_cmd_in(lock_cmd), .acq_cmd_in(acq_cmd), .rc_pin_out(rc_pin), .xtal_pin_out(xt_pin),
    .pll_pin_out(pll_pin), .lock_pin_out(lock_pin), .acq_pin_out(acq_pin));

  initial clk_sys_in = 1'b0;
  always #10 clk_sys_in = ~clk_sys_in;

  task final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk

  task rng(input string nm, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : rng

  // rise counters and per-cycle consumer clock equality
  always @(posedge clk_sys_in) begin
    prv <= {wd, xt, base, bus, pll_pin};
    n_wd += int'(wd & ~prv[4]);
    n_xt += int'(xt & ~prv[3]);
    n_base += int'(base & ~prv[2]);
    n_bus += int'(bus & ~prv[1]);
    n_pll += int'(pll_pin & ~prv[0]);
    if (arst_n_in) begin
      compares++;
      if (wd !== sy || xt !== pref || xt !== rtc) begin
        n_mismatch++;
        $display("MISMATCH consumer clocks exp equal got %b%b %b%b%b", wd, sy, xt, pref, rtc);
      end
    end
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= v;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask : wr

  task rchk(input string nm, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys_in);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1 d = rdata;
    chk(nm, e, d & m);
  endtask : rchk

  // settle, then count rises over a fixed span
  task win;
    repeat (10) @(posedge clk_sys_in);
    #1 {n_wd, n_xt, n_base, n_bus, n_pll} = '0;
    repeat (600) @(posedge clk_sys_in);
  endtask : win

  task t_reset_regs;
    rchk("ctrl", 3'h0, 8'hf0, 8'h00);
    rchk("cfg2", 3'h3, 8'h07, 8'h00);
    rchk("src", 3'h4, 8'h18, 8'h08);
    rchk("unmapped", 3'h5, 8'hff, 8'h00);
  endtask : t_reset_regs

  task t_run_wait;
    @(posedge clk_sys_in);
    wait_m <= 1'b1;
    win();
    rng("wd run", 20, 50, n_wd);
    rng("xt run", 40, 70, n_xt);
    @(posedge clk_sys_in);
    wait_m <= 1'b0;
  endtask : t_run_wait

  task t_sysint_en;
    @(posedge clk_sys_in);
    osc_en <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk("en off", 8'h00, {6'h00, rc_en, xt_en});
    @(posedge clk_sys_in);
    osc_en <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk("en on", 8'h03, {6'h00, rc_en, xt_en});
  endtask : t_sysint_en

  task stop_in(input logic [7:0] cfg);
    wr(3'h3, cfg);
    @(posedge clk_sys_in);
    stop_m <= 1'b1;
    osc_en <= 1'b0;
  endtask : stop_in

  task stop_out;
    @(posedge clk_sys_in);
    stop_m <= 1'b0;
    osc_en <= 1'b1;
    brk_m <= 1'b0;
  endtask : stop_out

  task t_stop;
    stop_in(8'h00);
    win();
    chk("stop dflt en", 8'h02, {6'h00, rc_en, xt_en});
    chk("stop xt", 8'h00, 8'(n_xt));
    rng("stop wd", 20, 50, n_wd);
    stop_out();
    stop_in(8'h03);
    wr(3'h3, 8'h00);
    win();
    chk("stop keep en", 8'h01, {6'h00, rc_en, xt_en});
    chk("stop wd", 8'h00, 8'(n_wd));
    rng("stop xt", 40, 70, n_xt);
    rchk("st keep", 3'h4, 8'h07, 8'h06);
    @(posedge clk_sys_in);
    brk_m <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk("break en", 8'h03, {6'h00, rc_en, xt_en});
    stop_out();
  endtask : t_stop

  task t_interlock;
    wr(3'h0, 8'h10);
    rchk("bcs pll off", 3'h0, 8'hf0, 8'h00);
    wr(3'h2, 8'h10);
    wr(3'h0, 8'hb0);
    rchk("ie auto off", 3'h0, 8'hf0, 8'h30);
    wr(3'h2, 8'h55);
    rchk("prog ro", 3'h2, 8'hff, 8'h10);
    chk("vrs out", 8'h10, vrs);
    wr(3'h0, 8'h10);
    rchk("pll on forced", 3'h0, 8'hf0, 8'h30);
    chk("pll on out", 8'h01, {7'h00, pll_on});
    // handover waits for both clocks low: up to two slow phases
    repeat (40) @(posedge clk_sys_in);
    rchk("src pll", 3'h4, 8'h18, {3'h0, ocg_pkg::SRC_PLL_DIV2, 3'h0});
  endtask : t_interlock

  task t_irq;
    wr(3'h1, 8'ha0);
    rchk("acq ro lo", 3'h1, 8'he0, 8'h80);
    @(posedge clk_sys_in);
    acq_cmd <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rchk("acq ro hi", 3'h1, 8'he0, 8'ha0);
    chk("acq out", 8'h01, {7'h00, acq_o});
    wr(3'h0, 8'hb0);
    @(posedge clk_sys_in);
    lock_cmd <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk("irq lock", 8'h01, {7'h00, irq});
    rchk("flag", 3'h0, 8'hf0, 8'hf0);
    rchk("lock", 3'h1, 8'he0, 8'he0);
    repeat (2) @(posedge clk_sys_in);
    chk("irq clr", 8'h00, {7'h00, irq});
    @(posedge clk_sys_in);
    lock_cmd <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    chk("irq unlock", 8'h01, {7'h00, irq});
    wr(3'h1, 8'h00);
    @(posedge clk_sys_in);
    lock_cmd <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rchk("lock manual", 3'h1, 8'hc0, 8'h00);
    rchk("flag manual", 3'h0, 8'hf0, 8'h30);
  endtask : t_irq

  task t_base;
    win();
    rng("base pll", n_pll / 2 - 3, n_pll / 2 + 3, n_base);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h04);
    win();
    rng("base xt", n_xt - 3, n_xt + 3, n_base);
    wr(3'h3, 8'h00);
    win();
    rng("base xt2", n_xt / 2 - 3, n_xt / 2 + 3, n_base);
    rng("bus", n_base / 2 - 2, n_base / 2 + 2, n_bus);
  endtask : t_base

  initial begin
    req = '0;
    arst_n_in = 1'b0;
    {osc_en, stop_m, wait_m, brk_m, lock_cmd, acq_cmd} = 6'b100000;
    repeat (10) @(posedge clk_sys_in);
    chk("reset en", 8'h03, {6'h00, rc_en, xt_en});
    arst_n_in <= 1'b1;
    t_reset_regs();
    t_run_wait();
    t_sysint_en();
    t_stop();
    t_interlock();
    t_irq();
    t_base();
    final_report();
  end
endmodule : testbench
